// ### hdl/cic_comb.sv
// Shared comb section, one delay chain per channel of all interfaces
`timescale 1ns/1ps
module cic_comb
    import cic_pkg::*;
#(
    parameter int W    = 42,
    parameter int N    = 8,
    parameter int CH   = 4,
    parameter int CH_W = 2
) (
    input  wire logic            sys_clk,
    input  wire logic            sys_rst,
    input  wire logic            ce,
    input  wire logic            clr,
    input  wire logic            in_valid,
    input  wire logic [W-1:0]    in_data,
    input  wire logic [CH_W-1:0] in_ch,
    output logic                 out_valid,
    output logic [W-1:0]         out_data,
    output logic [CH_W-1:0]      out_ch
);

    typedef struct packed {
        logic [CH-1:0][N-1:0][W-1:0] dly;
        logic                        ov;
        logic [W-1:0]                od;
        logic [CH_W-1:0]             och;
    } comb_state_s;

    comb_state_s  s_reg;
    comb_state_s  s_next;
    logic [W-1:0] v;
    logic [W-1:0] t;

    // Differential delay of one decimated sample per stage
    always_comb begin
        s_next    = s_reg;
        v         = in_data;
        t         = '0;
        s_next.ov = 1'b0;
        if (clr) begin
            s_next.dly = '0;
        end else if (in_valid) begin
            for (int k = 0; k < N; k++) begin
                t = v - s_reg.dly[in_ch][k];
                s_next.dly[in_ch][k] = v;
                v = t;
            end
            s_next.od  = v;
            s_next.ov  = 1'b1;
            s_next.och = in_ch;
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign out_valid = s_reg.ov;
    assign out_data  = s_reg.od;
    assign out_ch    = s_reg.och;

endmodule

// ### hdl/cic_decimator.sv
// Multichannel CIC decimator with programmable rate and AXI4-Lite control
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module cic_decimator
    import cic_pkg::*;
#(
    parameter int DIN_W           = 18,
    parameter int DOUT_W          = 18,
    parameter int N_STAGES        = 8,
    parameter int IF_NUM          = 1,
    parameter int CH_PER_IF       = 4,
    parameter int RATE_INIT       = 4,
    parameter int RATE_MIN        = 4,
    parameter int RATE_MAX        = 5,
    parameter bit USE_RAM         = 1'b0,
    parameter int MAX_SMALL_DEPTH = 64,
    localparam int TOT_CH         = IF_NUM * CH_PER_IF,
    localparam int TOT_W          = (TOT_CH > 1) ? $clog2(TOT_CH) : 1
) (
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       ce,
    input  wire axi_req_s                   axi_req,
    output axi_rsp_s                        axi_rsp,
    input  wire logic [IF_NUM*DIN_W-1:0]    din,
    input  wire logic                       din_valid,
    input  wire logic                       input_channel_sync,
    output logic [DOUT_W-1:0]               dout,
    output logic                            dout_valid,
    output logic                            output_channel_sync,
    output logic [TOT_W-1:0]                output_channel_number,
    output logic                            ready_for_data
);

    // Bit growth of the largest rate bounds every accumulator
    // width for max rate
    localparam int W_ACC = DIN_W + N_STAGES * $clog2(RATE_MAX);
    localparam int CH_W  = (CH_PER_IF > 1) ? $clog2(CH_PER_IF) : 1;

    // RAM kind of each store, reported in the status register
    // depth picks kind
    localparam logic INT_LARGE  = store_large(CH_PER_IF, MAX_SMALL_DEPTH, USE_RAM);
    localparam logic COMB_LARGE = store_large(TOT_CH, MAX_SMALL_DEPTH, USE_RAM);

    typedef struct packed {
        // Register slave
        logic                             awready;
        logic                             wready;
        logic                             aw_held;
        logic [7:0]                       aw_addr;
        logic                             w_held;
        logic [31:0]                      w_data;
        logic [3:0]                       w_strb;
        logic                             bvalid;
        logic [1:0]                       bresp;
        logic                             arready;
        logic                             rvalid;
        logic [31:0]                      rdata;
        logic [1:0]                       rresp;
        // Rate and reset sequence
        logic [RATE_W-1:0]                rate_pend;
        logic [RATE_W-1:0]                rate_act;
        logic [3:0]                       srst_cnt;
        logic                             ready;
        logic                             cont;
        // Channel and phase tracking
        logic [CH_W-1:0]                  in_ch;
        logic [IF_NUM-1:0][RATE_W-1:0]    phase;
        // Output stage
        logic [DOUT_W-1:0]                dout;
        logic                             dvalid;
        logic                             osync;
        logic [TOT_W-1:0]                 onum;
    } top_state_s;

    top_state_s s;
    top_state_s s_next;

    // Integrator outputs, one bank per interface
    logic [IF_NUM-1:0]             int_ov;
    logic [IF_NUM-1:0][W_ACC-1:0]  int_od;
    logic [IF_NUM-1:0][CH_W-1:0]   int_och;

    // Shared comb input and output
    logic              comb_iv;
    logic [W_ACC-1:0]  comb_id;
    logic [TOT_W-1:0]  comb_ic;
    logic              comb_ov;
    logic [W_ACC-1:0]  comb_od;
    logic [TOT_W-1:0]  comb_oc;

    logic              take;
    logic              clr;

    // Known register offsets, shared by the read and write paths
    function automatic logic reg_known(input logic [7:0] a);
        return (a == OFS_CTRL) || (a == OFS_RATE) || (a == OFS_STATUS);
    endfunction

    // Out-of-range rates are pulled to the nearest limit
    function automatic logic [RATE_W-1:0] rate_clamp(input logic [RATE_W-1:0] r);
        if (r < RATE_W'(RATE_MIN)) begin
            return RATE_W'(RATE_MIN);
        end else if (r > RATE_W'(RATE_MAX)) begin
            return RATE_W'(RATE_MAX);
        end
        return r;
    endfunction

    // Samples are dropped, not queued, while the reset sequence runs
    // gate input on ready
    assign take = din_valid && s.ready;
    assign clr  = !s.ready;

    // One integrator bank per interface slice of the input word
    genvar gi;
    generate
        for (gi = 0; gi < IF_NUM; gi++) begin : g_if
            cic_integrator #(
                .W_IN  (DIN_W),
                .W_ACC (W_ACC),
                .N     (N_STAGES),
                .CH    (CH_PER_IF),
                .CH_W  (CH_W)
            ) u_integ (
                .sys_clk   (sys_clk),
                .sys_rst   (sys_rst),
                .ce        (ce),
                .clr       (clr),
                .in_valid  (take),
                .in_data   (din[gi*DIN_W +: DIN_W]),
                .in_ch     (s.in_ch),
                .out_valid (int_ov[gi]),
                .out_data  (int_od[gi]),
                .out_ch    (int_och[gi])
            );
        end
    endgenerate

    // Comb shared by every channel of every interface
    cic_comb #(
        .W    (W_ACC),
        .N    (N_STAGES),
        .CH   (TOT_CH),
        .CH_W (TOT_W)
    ) u_comb (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .clr       (clr),
        .in_valid  (comb_iv),
        .in_data   (comb_id),
        .in_ch     (comb_ic),
        .out_valid (comb_ov),
        .out_data  (comb_od),
        .out_ch    (comb_oc)
    );

    // Next-state logic for bus, rate control, phase tracking and output
    always_comb begin
        s_next  = s;
        comb_iv = 1'b0;
        comb_id = '0;
        comb_ic = '0;

        // Write address and data are taken independently
        if (axi_req.awvalid && s.awready) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s.wready) begin
            s_next.w_held = 1'b1;
            s_next.w_data = axi_req.wdata;
            s_next.w_strb = axi_req.wstrb;
        end
        if (s.bvalid && axi_req.bready) begin
            s_next.bvalid = 1'b0;
        end

        // Reset sequence countdown; the pending rate becomes active at its end
        if (s.srst_cnt != 4'h0) begin
            s_next.srst_cnt = s.srst_cnt - 4'h1;
            s_next.dvalid   = 1'b0;
            s_next.osync    = 1'b0;
            s_next.in_ch    = '0;
            if (s.srst_cnt == 4'h1) begin
                s_next.rate_act = s.rate_pend;
                s_next.cont     = 1'b1;
                for (int i = 0; i < IF_NUM; i++) begin
                    s_next.phase[i] = (RATE_W'(i) < s.rate_pend) ? RATE_W'(i) : '0;
                end
            end
        end

        // A write completes once both halves are held and no answer is pending
        if (s.aw_held && s.w_held && !s.bvalid) begin
            s_next.aw_held = 1'b0;
            s_next.w_held  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = reg_known(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (s.aw_addr == OFS_CTRL && s.w_strb[0] && s.w_data[CTRL_SRST_BIT]) begin
                s_next.srst_cnt = RESET_CYCLES;
                s_next.ready    = 1'b0;
            end
            if (s.aw_addr == OFS_RATE && s.w_strb[0]) begin
                s_next.rate_pend = rate_clamp(s.w_data[RATE_W-1:0]);
            end
        end
        s_next.awready = !s_next.aw_held;
        s_next.wready  = !s_next.w_held;

        // Reads answer one cycle after the address is taken
        if (s.rvalid && axi_req.rready) begin
            s_next.rvalid = 1'b0;
        end
        if (axi_req.arvalid && s.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = reg_known(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
            s_next.rdata  = '0;
            unique case (axi_req.araddr)
                OFS_RATE: begin
                    s_next.rdata[RATE_W-1:0] = s.rate_pend;
                end
                OFS_STATUS: begin
                    s_next.rdata[STAT_READY_BIT]                   = s.ready;
                    s_next.rdata[STAT_RAM_BIT]                     = USE_RAM;
                    s_next.rdata[STAT_INT_LARGE_BIT]               = INT_LARGE;
                    s_next.rdata[STAT_COMB_LARGE_BIT]              = COMB_LARGE;
                    s_next.rdata[STAT_RATE_LSB +: RATE_W]          = s.rate_act;
                end
                default: begin
                    s_next.rdata = '0;
                end
            endcase
        end
        s_next.arready = !s_next.rvalid;

        // Ready rises when the countdown reaches zero
        // ready after sequence
        if (s.srst_cnt != 4'h0) begin
            s_next.ready = (s_next.srst_cnt == 4'h0);
        end

        // A result in flight when the clearing sequence starts is dropped, data held
        if (s.ready && s_next.ready) begin
            // Input sync marks the last channel, so the next sample is channel 0
            // sync precedes channel 0
            if (take) begin
                if (input_channel_sync || s.in_ch == CH_W'(CH_PER_IF - 1)) begin
                    s_next.in_ch = '0;
                end else begin
                    s_next.in_ch = s.in_ch + 1'b1;
                end
            end
            // A gap in the input ends continuous mode
            if (!din_valid) begin
                s_next.cont = 1'b0;
            end

            // Each interface emits all its channels at the last sample of its period; of interfaces on one phase only the lowest-numbered reaches the comb
            // one output per rate samples
            for (int i = IF_NUM - 1; i >= 0; i--) begin
                if (int_ov[i] && s.phase[i] == RATE_W'(s.rate_act - 1'b1)) begin
                    comb_iv = 1'b1;
                    comb_id = int_od[i];
                    comb_ic = TOT_W'(i * CH_PER_IF) + TOT_W'(int_och[i]);
                end
            end
            // Phase advances once per sample set, after the last channel
            for (int i = 0; i < IF_NUM; i++) begin
                if (int_ov[i] && int_och[i] == CH_W'(CH_PER_IF - 1)) begin
                    if (s.phase[i] == RATE_W'(s.rate_act - 1'b1)) begin
                        s_next.phase[i] = '0;
                    end else begin
                        s_next.phase[i] = s.phase[i] + 1'b1;
                    end
                end
            end

            // Valid follows the comb; bursts and gaps fall out of the phase logic
            // valid per emitted sample
            s_next.dvalid = comb_ov;
            if (comb_ov) begin
                s_next.dout = comb_od[W_ACC-1 -: DOUT_W];
                s_next.onum = comb_oc;
            end
            if (TOT_CH == 1 && s.cont) begin
                s_next.osync = s.osync || comb_ov;
            end else begin
                s_next.osync = comb_ov && (comb_oc == '0);
            end
        end else begin
            s_next.dvalid = 1'b0;
            s_next.osync  = 1'b0;
        end
    end

    // Single state register; the async branch loads constants only
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s           <= '0;
            s.awready   <= 1'b1;
            s.wready    <= 1'b1;
            s.arready   <= 1'b1;
            s.rate_pend <= RATE_W'(RATE_INIT);
            s.rate_act  <= RATE_W'(RATE_INIT);
            s.srst_cnt  <= RESET_CYCLES;
        end else if (ce) begin
            s <= s_next;
        end
    end

    // Every top-level output is a state bit
    assign axi_rsp.awready        = s.awready;
    assign axi_rsp.wready         = s.wready;
    assign axi_rsp.bvalid         = s.bvalid;
    assign axi_rsp.bresp          = s.bresp;
    assign axi_rsp.arready        = s.arready;
    assign axi_rsp.rvalid         = s.rvalid;
    assign axi_rsp.rdata          = s.rdata;
    assign axi_rsp.rresp          = s.rresp;
    assign dout                   = s.dout;
    assign dout_valid             = s.dvalid;
    assign output_channel_sync    = s.osync;
    assign output_channel_number  = s.onum;
    assign ready_for_data         = s.ready;

endmodule

// ### hdl/cic_integrator.sv
// Integrator bank of one interface, one accumulator chain per time-share channel
`timescale 1ns/1ps
module cic_integrator
    import cic_pkg::*;
#(
    parameter int W_IN  = 18,
    parameter int W_ACC = 42,
    parameter int N     = 8,
    parameter int CH    = 4,
    parameter int CH_W  = 2
) (
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  wire logic                    ce,
    input  wire logic                    clr,
    input  wire logic                    in_valid,
    input  wire logic signed [W_IN-1:0]  in_data,
    input  wire logic [CH_W-1:0]         in_ch,
    output logic                         out_valid,
    output logic [W_ACC-1:0]             out_data,
    output logic [CH_W-1:0]              out_ch
);

    typedef struct packed {
        logic [CH-1:0][N-1:0][W_ACC-1:0] acc;
        logic                            ov;
        logic [W_ACC-1:0]                od;
        logic [CH_W-1:0]                 och;
    } integ_state_s;

    integ_state_s     s_reg;
    integ_state_s     s_next;
    logic [W_ACC-1:0] v;

    // Chain of running sums; wrap-around is harmless since combs undo it
    always_comb begin
        s_next    = s_reg;
        v         = W_ACC'(in_data);
        s_next.ov = 1'b0;
        if (clr) begin
            s_next.acc = '0;
        end else if (in_valid) begin
            for (int k = 0; k < N; k++) begin
                v = v + s_reg.acc[in_ch][k];
                s_next.acc[in_ch][k] = v;
            end
            s_next.od  = v;
            s_next.ov  = 1'b1;
            s_next.och = in_ch;
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign out_valid = s_reg.ov;
    assign out_data  = s_reg.od;
    assign out_ch    = s_reg.och;

endmodule

// ### hdl/cic_pkg.sv
// Register map, reset constants and bus carriers for the CIC decimator
package cic_pkg;

    // Rate field width and reset sequence length
    localparam int         RATE_W       = 8;
    localparam logic [3:0] RESET_CYCLES = 4'h4;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_RATE   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;

    // Field positions
    localparam int CTRL_SRST_BIT       = 0;
    localparam int STAT_READY_BIT      = 0;
    localparam int STAT_RAM_BIT        = 1;
    localparam int STAT_INT_LARGE_BIT  = 2;
    localparam int STAT_COMB_LARGE_BIT = 3;
    localparam int STAT_RATE_LSB       = 8;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Master to slave signals
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axi_req_s;

    // Slave to master signals
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_s;

    // Large RAM kind is chosen when RAM is used and a store is deeper than the small kind allows
    function automatic logic store_large(input int depth, input int max_small, input bit use_ram);
        return use_ram && (depth > max_small);
    endfunction

endpackage

// ### tb/cic_decimator_asserts.sv
// Port-level properties of the CIC decimator in a single-channel setup
`timescale 1ns/1ps
module cic_decimator_asserts
    import cic_pkg::*;
#(
    parameter int  DIN_W     = 18,
    parameter int  DOUT_W    = 18,
    parameter int  IF_NUM    = 1,
    parameter int  CH_PER_IF = 4,
    localparam int TOT_CH    = IF_NUM * CH_PER_IF,
    localparam int TOT_W     = (TOT_CH > 1) ? $clog2(TOT_CH) : 1
) (
    input wire logic                    sys_clk,
    input wire logic                    sys_rst,
    input wire logic                    ce,
    input wire axi_req_s                axi_req,
    input wire axi_rsp_s                axi_rsp,
    input wire logic [IF_NUM*DIN_W-1:0] din,
    input wire logic                    din_valid,
    input wire logic                    input_channel_sync,
    input wire logic [DOUT_W-1:0]       dout,
    input wire logic                    dout_valid,
    input wire logic                    output_channel_sync,
    input wire logic [TOT_W-1:0]        output_channel_number,
    input wire logic                    ready_for_data
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // Clearing sequence holds ready low for four cycles before it returns
    sequence s_low4;
        !ready_for_data [*4];
    endsequence

    property p_por_ready;
        $fell(sys_rst) |-> !ready_for_data ##[3:6] ready_for_data;
    endproperty
    property p_srst_ready;
        $fell(ready_for_data) |-> s_low4 ##[1:2] ready_for_data;
    endproperty
    property p_quiet;
        !ready_for_data |-> !dout_valid;
    endproperty
    // Two samples at least are needed before the first result can leave
    property p_first_out;
        $rose(ready_for_data) |-> !dout_valid [*3];
    endproperty
    property p_pulse;
        dout_valid |=> !dout_valid;
    endproperty
    property p_hold;
        !dout_valid |-> $stable(dout) && $stable(output_channel_number);
    endproperty
    property p_chan_zero;
        output_channel_number == '0;
    endproperty
    property p_sync_with_valid;
        dout_valid |-> output_channel_sync;
    endproperty

    a_por_ready: assert property (p_por_ready) else $error("ready timing after reset wrong");
    a_srst_ready: assert property (p_srst_ready) else $error("clearing sequence length wrong");
    a_quiet: assert property (p_quiet) else $error("output while not ready");
    a_first_out: assert property (p_first_out) else $error("output too soon after ready");
    a_pulse: assert property (p_pulse) else $error("output valid longer than one cycle");
    a_hold: assert property (p_hold) else $error("output changed between valids");
    a_chan_zero: assert property (p_chan_zero) else $error("channel number not zero");
    a_sync_with_valid: assert property (p_sync_with_valid) else $error("sync missing on output");
endmodule

bind cic_decimator cic_decimator_asserts #(
    .DIN_W(DIN_W), .DOUT_W(DOUT_W), .IF_NUM(IF_NUM), .CH_PER_IF(CH_PER_IF)
) u_asserts (.*);

// ### tb/cic_source_model.sv
// Upstream sample source feeding a constant level, with or without gaps
`timescale 1ns/1ps
module cic_source_model #(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         gapped,
    input  wire logic         sync_high,
    input  wire logic [W-1:0] level,
    output logic [W-1:0]      din,
    output logic              din_valid,
    output logic              input_channel_sync
);
    logic nv;

    initial begin
        din = '0;
        din_valid = 1'b0;
        input_channel_sync = 1'b0;
    end

    // Next slot is valid every clock, or every other clock when gapped
    always_comb nv = !gapped || !din_valid;

    // Samples keep coming while ready is low; idle slots carry the inverse
    // sync copy or held; whole word is slice 0
    always @(posedge sys_clk) begin
        din_valid <= nv;
        input_channel_sync <= sync_high || nv;
        din <= nv ? level : ~level;
    end
endmodule

// ### tb/tb.sv
// Self-checking bench for the CIC decimator, one channel, rates 2 and 3
`timescale 1ns/1ps
module tb;
    import cic_pkg::*;
    localparam int W = 8;
    logic         sys_clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         ce = 1'b1;
    axi_req_s     axi_req = '0;
    axi_rsp_s     axi_rsp;
    logic [W-1:0] din, dout, e2, e3;
    logic [W-1:0] level = '0;
    logic         din_valid, input_channel_sync, dout_valid, output_channel_sync, ready_for_data;
    logic [0:0]   output_channel_number;
    logic         gapped = 1'b0;
    logic         sync_high = 1'b1;
    logic [7:0]   gap_cnt = 8'h00;
    logic [17:0]  oq[$];
    logic [33:0]  rq[$];
    int           err_total = 0;
    int           checks_done = 0;

    always #4 sys_clk = ~sys_clk;

    // Small widths keep the DC gain easy to predict
    cic_decimator #(.DIN_W(W), .DOUT_W(W), .N_STAGES(2), .CH_PER_IF(1), .RATE_INIT(2),
        .RATE_MIN(2), .RATE_MAX(3)) uut (.*);
    cic_source_model #(.W(W)) src (.*);

    task automatic chk_out(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Scoreboard: oldest note against each result, settled at the falling edge
    always @(negedge sys_clk) begin
        gap_cnt <= gap_cnt + 8'h01;
        if (dout_valid) begin
            gap_cnt <= 8'h01;
            if (oq.size() > 0) chk_out({gap_cnt, dout, output_channel_sync, output_channel_number}, oq.pop_front());
        end
        if (axi_rsp.rvalid && axi_req.rready && rq.size() > 0)
            chk_reg({axi_rsp.rresp, axi_rsp.rdata & 32'h0000ff0f}, rq.pop_front());
    end

    // Let the filter settle, then note spacing and steady value of n results
    task automatic expect_out(input int n, input logic [7:0] g, input logic [W-1:0] e);
        repeat (40) @(posedge sys_clk);
        repeat (n) oq.push_back({g, e, 2'b10});
        while (oq.size() > 0) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_req.awaddr <= a;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hf;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (!axi_rsp.bvalid);
        axi_req.bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (!axi_rsp.rvalid);
        axi_req.rready <= 1'b0;
        // One idle edge so a following read does not re-raise rready at once
        @(posedge sys_clk);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence; a positive level keeps the truncated DC value exact
    initial begin
        void'($urandom(32'h0196));
        level = W'(8'h01 + $urandom % 127);
        e2 = level >> 2;
        e3 = W'((int'(level) * 9) >> 4);
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        while (!ready_for_data) @(posedge sys_clk);
        expect_out(4, 8'h02, e2);
        $display("test continuous done");
        gapped <= 1'b1;
        sync_high <= 1'b0;
        expect_out(4, 8'h04, e2);
        $display("test gapped done");
        gapped <= 1'b0;
        sync_high <= 1'b1;
        // A rate below the minimum is pulled up to the lower limit
        wr(OFS_RATE, 32'h00000001);
        rd(OFS_RATE, {RESP_OKAY, 32'h00000002});
        wr(OFS_RATE, 32'h00000003);
        rd(OFS_STATUS, {RESP_OKAY, 32'h00000201});
        rd(OFS_RATE, {RESP_OKAY, 32'h00000003});
        rd(8'h0c, {RESP_SLVERR, 32'h00000000});
        expect_out(4, 8'h02, e2);
        wr(OFS_CTRL, 32'h00000001);
        repeat (2) @(posedge sys_clk);
        while (!ready_for_data) @(posedge sys_clk);
        rd(OFS_STATUS, {RESP_OKAY, 32'h00000301});
        expect_out(4, 8'h03, e3);
        $display("test rate change done");
        final_report;
    end

    // Watchdog well beyond the expected run of about 250 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        final_report;
    end
endmodule
